// ==== design/ddc_dispatch_top.sv ====
// dual dispatch, completion and branch resource control
//
// Behaviour
// - at most 12 instructions in flight, retire queue plus fetch queue
// - retire queue tracks six entries; dispatch stalls while it is full
// - six integer renames; no dispatch without a free one
// - load with address update takes two integer renames
// - six float renames bound float destinations in flight
// - only slots 0 and 1 dispatch, at most two a cycle
// - slot 0 needs unit, renames, queue room, no completion-serialized in flight
// - slot 1 only with slot 0, which is not completion or refetch serialized
// - slot 1 resources are counted after what slot 0 takes
// - oldest entry retires when finished, not behind unresolved branch, no exception
// - second entry retires only with the oldest and under the same checks
// - second entry retires only if integer or load
// - dual retire limited to two condition, two integer, two float updates
// - return-address branch needs that register, loop-count branch needs count register
// - branch-and-link needs a free shadow return address copy
// - counter-decrement branch needs count register free or condition false
// - condition-field branch waits while an earlier predicted branch is unresolved
// - relative branches without register updates fold if taken, else fall through
`timescale 1ns/1ps
module ddc_dispatch_top #(
   parameter int INT_REN = ddc_pkg::INT_REN_CNT,
   parameter int FP_REN  = ddc_pkg::FP_REN_CNT,
   parameter int SHADOW  = ddc_pkg::SHADOW_CNT
) (
   input  wire logic                      sys_clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic [1:0]                fetch_push_in,
   output wire logic [2:0]                fetch_room_out,
   input  wire ddc_pkg::ddc_instr_s       slot0_in,
   input  wire ddc_pkg::ddc_instr_s       slot1_in,
   input  wire logic [ddc_pkg::N_UNITS-1:0] unit_free_in,
   output wire logic                      disp0_out,
   output wire logic                      disp1_out,
   output wire logic [ddc_pkg::TAG_W-1:0] tag0_out,
   output wire logic [ddc_pkg::TAG_W-1:0] tag1_out,
   input  wire logic                      fin_vld_in,
   input  wire logic [ddc_pkg::TAG_W-1:0] fin_tag_in,
   input  wire logic                      fin_exc_in,
   output wire logic                      ret0_out,
   output wire logic                      ret1_out,
   output wire logic                      head_exc_out,
   input  wire logic                      br_vld_in,
   input  wire ddc_pkg::ddc_br_e          br_kind_in,
   input  wire logic                      br_link_in,
   input  wire logic                      br_cr_cond_in,
   input  wire logic                      br_taken_in,
   input  wire logic                      cond_false_in,
   input  wire logic                      ret_busy_in,
   input  wire logic                      loop_busy_in,
   input  wire logic                      pred_unres_in,
   input  wire logic                      pred_resolve_in,
   input  wire logic                      shadow_release_in,
   output wire logic                      br_ok_out,
   output wire logic                      br_fold_out,
   output wire logic                      br_fall_out,
   output wire logic                      fetch_stall_out,
   output logic                           br_waiting_out,
   output logic [ddc_pkg::CNT_W-1:0]      fq_count_out,
   output logic [ddc_pkg::CNT_W-1:0]      int_free_out,
   output logic [ddc_pkg::CNT_W-1:0]      fp_free_out,
   output logic [ddc_pkg::CNT_W-1:0]      shadow_free_out
);
   import ddc_pkg::*;

   if (INT_REN < 2 || INT_REN > 15 || FP_REN < 1 || FP_REN > 15
       || SHADOW < 1 || SHADOW > 15) begin : g_chk
      $error("rename or shadow count out of range");
   end

   ddc_rq_if rq ();

   ddc_retire_ctl #(
      .DEPTH (RQ_DEPTH)
   ) u_retire (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .rq         (rq.ctl)
   );

   logic [CNT_W-1:0] fq_r;
   logic [CNT_W-1:0] int_free_r;
   logic [CNT_W-1:0] fp_free_r;
   logic [CNT_W-1:0] shadow_r;
   ddc_brs_e         brs_r;
   ddc_brs_e         brs_nxt;

   // ---- fetch queue occupancy and the in-flight ceiling
   wire [CNT_W-1:0] flight    = fq_r + rq.count;
   wire [CNT_W-1:0] fq_space  = CNT_W'(FQ_DEPTH) - fq_r;
   wire [CNT_W-1:0] tot_space = CNT_W'(TOTAL_MAX) - flight;
   wire [CNT_W-1:0] room      = (fq_space < tot_space) ? fq_space : tot_space;
   // only two fetch lanes exist, so the offer never exceeds two
   assign fetch_room_out = (room > 4'd2) ? 3'd2 : room[2:0];

   // ---- rename needs per slot
   wire [CNT_W-1:0] int_need0 = slot0_in.load_upd ? 4'd2 : CNT_W'(slot0_in.int_dst);
   wire [CNT_W-1:0] int_need1 = slot1_in.load_upd ? 4'd2 : CNT_W'(slot1_in.int_dst);
   wire [CNT_W-1:0] fp_need0  = CNT_W'(slot0_in.fp_dst);
   wire [CNT_W-1:0] fp_need1  = CNT_W'(slot1_in.fp_dst);

   // ---- execution unit availability, with what slot 0 takes removed for slot 1
   logic [N_UNITS-1:0] unit_left;
   for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
      assign unit_left[u] = unit_free_in[u]
                            && !(disp0_out && slot0_in.unit == ddc_unit_e'(u));
   end

   wire rq_room0 = rq.count < CNT_W'(RQ_DEPTH);
   wire rq_room1 = rq.count + 4'd1 < CNT_W'(RQ_DEPTH);
   wire int_ok0  = int_need0 <= int_free_r;
   wire fp_ok0   = fp_need0 <= fp_free_r;
   wire int_ok1  = int_need0 + int_need1 <= int_free_r;
   wire fp_ok1   = fp_need0 + fp_need1 <= fp_free_r;
   wire fq_has0  = fq_r != '0;
   wire fq_has1  = fq_r > 4'd1;

   // only the two bottom fetch queue entries are ever looked at
   assign disp0_out = slot0_in.vld && fq_has0 && unit_free_in[slot0_in.unit]
                      && int_ok0 && fp_ok0 && rq_room0 && !rq.cs_busy;
   assign disp1_out = disp0_out && slot1_in.vld && fq_has1
                      && !slot0_in.comp_ser && !slot0_in.refetch_ser
                      && unit_left[slot1_in.unit] && int_ok1 && fp_ok1 && rq_room1;

   assign tag0_out = rq.tag0;
   assign tag1_out = rq.tag1;

   // ---- retire queue hookup
   assign rq.push0        = disp0_out;
   assign rq.push1        = disp1_out;
   assign rq.ent0         = '{int_cnt: int_need0[1:0], fp_cnt: slot0_in.fp_dst,
                              cr_upd: slot0_in.cr_upd, int_or_load: slot0_in.int_or_load,
                              comp_ser: slot0_in.comp_ser};
   assign rq.ent1         = '{int_cnt: int_need1[1:0], fp_cnt: slot1_in.fp_dst,
                              cr_upd: slot1_in.cr_upd, int_or_load: slot1_in.int_or_load,
                              comp_ser: slot1_in.comp_ser};
   assign rq.after_pred   = pred_unres_in;
   assign rq.fin_vld      = fin_vld_in;
   assign rq.fin_tag      = fin_tag_in;
   assign rq.fin_exc      = fin_exc_in;
   assign rq.pred_resolve = pred_resolve_in;
   assign ret0_out        = rq.ret0;
   assign ret1_out        = rq.ret1;
   assign head_exc_out    = rq.head_exc;

   // ---- branch resolution
   wire is_rel = br_kind_in == BR_REL_UNCOND || br_kind_in == BR_REL_COND;
   wire reg_ok = (br_kind_in == BR_TO_RET) ? !ret_busy_in
               : (br_kind_in == BR_TO_LOOP) ? !loop_busy_in
               : (br_kind_in == BR_LOOP_DEC_COND) ? (!loop_busy_in || cond_false_in)
               : 1'b1;
   wire cr_ok   = !(br_cr_cond_in && pred_unres_in);
   wire link_ok = !br_link_in || shadow_r != '0;
   assign br_ok_out       = br_vld_in && reg_ok && cr_ok && link_ok;
   assign fetch_stall_out = br_vld_in && !br_ok_out;
   // a link writes the return register, so such a branch is never folded
   assign br_fold_out = br_ok_out && is_rel && !br_link_in && br_taken_in;
   assign br_fall_out = br_ok_out && is_rel && !br_link_in && !br_taken_in;

   always_comb begin
      brs_nxt = brs_r;
      case (brs_r)
         BRS_IDLE: begin
            if (fetch_stall_out) begin
               brs_nxt = BRS_STALL;
            end
         end
         BRS_STALL: begin
            if (!fetch_stall_out) begin
               brs_nxt = BRS_IDLE;
            end
         end
         default: brs_nxt = BRS_IDLE;
      endcase
   end

   wire shadow_take = br_ok_out && br_link_in;
   wire shadow_give = shadow_release_in && shadow_r != CNT_W'(SHADOW);

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         fq_r       <= '0;
         int_free_r <= CNT_W'(INT_REN);
         fp_free_r  <= CNT_W'(FP_REN);
         shadow_r   <= CNT_W'(SHADOW);
         brs_r      <= BRS_IDLE;
      end else begin
         fq_r       <= fq_r + CNT_W'(fetch_push_in) - CNT_W'(disp0_out) - CNT_W'(disp1_out);
         int_free_r <= int_free_r - (disp0_out ? int_need0 : 4'd0)
                       - (disp1_out ? int_need1 : 4'd0) + CNT_W'(rq.ret_int);
         fp_free_r  <= fp_free_r - (disp0_out ? fp_need0 : 4'd0)
                       - (disp1_out ? fp_need1 : 4'd0) + CNT_W'(rq.ret_fp);
         shadow_r   <= shadow_r - CNT_W'(shadow_take) + CNT_W'(shadow_give);
         brs_r      <= brs_nxt;
      end
   end

   assign br_waiting_out  = brs_r == BRS_STALL;
   assign fq_count_out    = fq_r;
   assign int_free_out    = int_free_r;
   assign fp_free_out     = fp_free_r;
   assign shadow_free_out = shadow_r;

   // ---- checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_ser_go;
      disp0_out && (slot0_in.comp_ser || slot0_in.refetch_ser);
   endsequence
   sequence s_cs_dispatched;
      disp0_out && slot0_in.comp_ser;
   endsequence

   a_flight_cap: assert property (fq_r + rq.count <= 4'd12)
      else $error("more than twelve instructions in flight");
   a_rq_full_stall: assert property (rq.count == 4'd6 |-> !disp0_out)
      else $error("dispatch while retire queue full");
   a_int_rename_cap: assert property (int_free_r <= 4'd6 ##1 int_free_r <= 4'd6)
      else $error("integer rename count overflow");
   a_load_upd_two: assert property (disp0_out && slot0_in.load_upd && !disp1_out
      && rq.ret_int == 3'd0 |=> int_free_r == $past(int_free_r) - 4'd2)
      else $error("load with update did not take two renames");
   a_fp_rename_cap: assert property (fp_free_r <= 4'd6)
      else $error("float rename count overflow");
   a_slot1_needs_0: assert property (disp1_out |-> disp0_out)
      else $error("slot 1 dispatched alone");
   a_ser_blocks_1: assert property (s_ser_go |-> !disp1_out)
      else $error("slot 1 dispatched behind serialized slot 0");
   a_cs_blocks: assert property (s_cs_dispatched |=> !disp0_out)
      else $error("dispatch while completion-serialized in flight");
   a_unit_shared: assert property (disp1_out && slot0_in.unit == slot1_in.unit
      |-> 1'b0)
      else $error("one unit granted to both slots");
   a_cr_wait: assert property (br_vld_in && br_cr_cond_in && pred_unres_in
      |-> fetch_stall_out ##1 (br_waiting_out || !br_vld_in))
      else $error("condition branch ran past unresolved prediction");
   a_link_shadow: assert property (br_vld_in && br_link_in && shadow_r == '0
      |-> !br_ok_out)
      else $error("link branch resolved without shadow copy");
   a_fold_rel: assert property (br_fold_out |-> is_rel && br_taken_in && !br_link_in)
      else $error("fold of a non-relative branch");
endmodule

// ==== design/ddc_pkg.sv ====
// constants and types for the dual dispatch and completion control
package ddc_pkg;
   localparam int TOTAL_MAX     = 12;
   localparam int RQ_DEPTH      = 6;
   localparam int FQ_DEPTH      = 6;
   localparam int INT_REN_CNT   = 6;
   localparam int FP_REN_CNT    = 6;
   localparam int SHADOW_CNT    = 1;
   localparam int DUAL_UPD_MAX  = 2;
   localparam int N_UNITS       = 4;
   localparam int CNT_W         = 4;
   localparam int TAG_W         = 3;

   typedef enum logic [1:0] {
      UNIT_INT = 2'b00,
      UNIT_LSU = 2'b01,
      UNIT_FPU = 2'b10,
      UNIT_SYS = 2'b11
   } ddc_unit_e;

   typedef enum logic [2:0] {
      BR_REL_UNCOND    = 3'b000,
      BR_REL_COND      = 3'b001,
      BR_TO_RET        = 3'b010,
      BR_TO_LOOP       = 3'b011,
      BR_LOOP_DEC_COND = 3'b100
   } ddc_br_e;

   typedef enum logic {
      BRS_IDLE  = 1'b0,
      BRS_STALL = 1'b1
   } ddc_brs_e;

   typedef struct packed {
      logic      vld;
      ddc_unit_e unit;
      logic      load_upd;
      logic      int_dst;
      logic      fp_dst;
      logic      cr_upd;
      logic      int_or_load;
      logic      comp_ser;
      logic      refetch_ser;
   } ddc_instr_s;

   typedef struct packed {
      logic [1:0] int_cnt;
      logic       fp_cnt;
      logic       cr_upd;
      logic       int_or_load;
      logic       comp_ser;
   } ddc_entry_s;
endpackage

// ==== design/ddc_retire_ctl.sv ====
// retire queue: entry storage and the two-oldest completion decision
`timescale 1ns/1ps
module ddc_retire_ctl #(
   parameter int DEPTH = ddc_pkg::RQ_DEPTH
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   ddc_rq_if.ctl     rq
);
   import ddc_pkg::*;

   if (DEPTH < 2 || DEPTH > (1 << TAG_W)) begin : g_chk
      $error("retire queue depth out of range");
   end

   ddc_entry_s       ent_r [DEPTH];
   logic [DEPTH-1:0] vld_r;
   logic [DEPTH-1:0] fin_r;
   logic [DEPTH-1:0] exc_r;
   logic [DEPTH-1:0] aft_r;
   logic [DEPTH-1:0] cs_vec;
   logic [TAG_W-1:0] head_r;
   logic [TAG_W-1:0] tail_r;
   logic [CNT_W-1:0] cnt_r;

   function automatic logic [TAG_W-1:0] inc(input logic [TAG_W-1:0] p);
      inc = (p == TAG_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   wire [TAG_W-1:0] h1 = inc(head_r);
   wire [TAG_W-1:0] t1 = inc(tail_r);
   wire ok0 = vld_r[head_r] && fin_r[head_r] && !aft_r[head_r] && !exc_r[head_r];
   wire [2:0] cr_sum  = 3'(ent_r[head_r].cr_upd) + 3'(ent_r[h1].cr_upd);
   wire [2:0] int_sum = 3'(ent_r[head_r].int_cnt) + 3'(ent_r[h1].int_cnt);
   wire [2:0] fp_sum  = 3'(ent_r[head_r].fp_cnt) + 3'(ent_r[h1].fp_cnt);
   wire upd_ok = (cr_sum <= 3'(DUAL_UPD_MAX)) && (int_sum <= 3'(DUAL_UPD_MAX))
                 && (fp_sum <= 3'(DUAL_UPD_MAX));
   wire ok1 = ok0 && vld_r[h1] && fin_r[h1] && !aft_r[h1] && !exc_r[h1]
              && ent_r[h1].int_or_load && upd_ok;

   assign rq.ret0     = ok0;
   assign rq.ret1     = ok1;
   assign rq.ret_int  = (ok0 ? 3'(ent_r[head_r].int_cnt) : 3'd0)
                        + (ok1 ? 3'(ent_r[h1].int_cnt) : 3'd0);
   assign rq.ret_fp   = (ok0 ? 2'(ent_r[head_r].fp_cnt) : 2'd0)
                        + (ok1 ? 2'(ent_r[h1].fp_cnt) : 2'd0);
   assign rq.tag0     = tail_r;
   assign rq.tag1     = rq.push0 ? t1 : tail_r;
   assign rq.count    = cnt_r;
   assign rq.head_exc = vld_r[head_r] && exc_r[head_r];
   assign rq.cs_busy  = |cs_vec;

   wire [CNT_W-1:0] n_in  = CNT_W'(rq.push0) + CNT_W'(rq.push1);
   wire [CNT_W-1:0] n_out = CNT_W'(ok0) + CNT_W'(ok1);

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      wire w0  = rq.push0 && tail_r == TAG_W'(i);
      wire w1  = rq.push1 && rq.tag1 == TAG_W'(i);
      wire r0  = ok0 && head_r == TAG_W'(i);
      wire r1  = ok1 && h1 == TAG_W'(i);
      wire fin = rq.fin_vld && rq.fin_tag == TAG_W'(i);
      assign cs_vec[i] = vld_r[i] && ent_r[i].comp_ser;
      always_ff @(posedge sys_clk_in) begin
         if (!rst_n_in) begin
            vld_r[i] <= 1'b0;
            fin_r[i] <= 1'b0;
            exc_r[i] <= 1'b0;
            aft_r[i] <= 1'b0;
            ent_r[i] <= '0;
         end else if (w0 || w1) begin
            vld_r[i] <= 1'b1;
            fin_r[i] <= 1'b0;
            exc_r[i] <= 1'b0;
            aft_r[i] <= rq.after_pred && !rq.pred_resolve;
            ent_r[i] <= w0 ? rq.ent0 : rq.ent1;
         end else begin
            if (r0 || r1) begin
               vld_r[i] <= 1'b0;
            end
            if (fin) begin
               fin_r[i] <= 1'b1;
               exc_r[i] <= rq.fin_exc;
            end
            if (rq.pred_resolve) begin
               aft_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         head_r <= '0;
         tail_r <= '0;
         cnt_r  <= '0;
      end else begin
         head_r <= ok1 ? inc(h1) : (ok0 ? h1 : head_r);
         tail_r <= rq.push1 ? inc(rq.tag1) : (rq.push0 ? t1 : tail_r);
         cnt_r  <= cnt_r + n_in - n_out;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_second_needs_first: assert property (rq.ret1 |-> rq.ret0)
      else $error("second entry retired without the oldest");
   a_second_int_only: assert property (rq.ret1 |-> ent_r[h1].int_or_load)
      else $error("non integer entry retired from second place");
   a_dual_upd_cap: assert property (rq.ret1 |-> int_sum <= 3'd2 && fp_sum <= 3'd2)
      else $error("dual completion exceeded update limit");
   a_head_unfinished: assert property (vld_r[head_r] && !fin_r[head_r] |-> !rq.ret0)
      else $error("unfinished head entry retired");
endmodule

// ==== design/ddc_rq_if.sv ====
// signals between dispatch control and the retire queue
`timescale 1ns/1ps
interface ddc_rq_if;
   import ddc_pkg::*;
   logic                   push0;
   logic                   push1;
   ddc_entry_s             ent0;
   ddc_entry_s             ent1;
   logic                   after_pred;
   logic [TAG_W-1:0]       tag0;
   logic [TAG_W-1:0]       tag1;
   logic                   fin_vld;
   logic [TAG_W-1:0]       fin_tag;
   logic                   fin_exc;
   logic                   pred_resolve;
   logic [CNT_W-1:0]       count;
   logic                   ret0;
   logic                   ret1;
   logic [2:0]             ret_int;
   logic [1:0]             ret_fp;
   logic                   head_exc;
   logic                   cs_busy;

   modport ctl (input push0, push1, ent0, ent1, after_pred, fin_vld, fin_tag, fin_exc,
                pred_resolve,
                output tag0, tag1, count, ret0, ret1, ret_int, ret_fp, head_exc, cs_busy);
   modport dsp (output push0, push1, ent0, ent1, after_pred, fin_vld, fin_tag, fin_exc,
                pred_resolve,
                input tag0, tag1, count, ret0, ret1, ret_int, ret_fp, head_exc, cs_busy);
endinterface

// ==== testbench/ddc_dispatch_top_test.sv ====
// self-checking bench for the dispatch and completion control
`timescale 1ns/1ps
module ddc_dispatch_top_test;
   import ddc_pkg::*;
   typedef struct packed {logic [3:0] s; logic [7:0] e;} ddc_note_s;
   logic sys_clk_in = 1'b0, rst_n_in, pred_unres_in, pred_resolve_in, shadow_release_in;
   logic br_vld_in, br_link_in, br_cr_cond_in, br_taken_in, cond_false_in, ret_busy_in;
   logic loop_busy_in, fin_vld_in, fin_exc_in, disp0_out, disp1_out, ret0_out, ret1_out;
   logic head_exc_out, br_ok_out, br_fold_out, br_fall_out, fetch_stall_out, br_waiting_out;
   logic hold = 1'b0, hf, rev, exc;
   logic [1:0] fetch_push_in;
   logic [2:0] fetch_room_out, tag0_out, tag1_out, fin_tag_in;
   logic [3:0] unit_free_in, fq_count_out, int_free_out, fp_free_out, shadow_free_out;
   ddc_instr_s slot0_in, slot1_in, i_int, i_nod, i_ldu, i_ld, i_fpd, i_cs, none;
   ddc_br_e    br_kind_in;
   ddc_note_s  q[$];
   int num_errors = 0, comparisons = 0, n_ret = 0, n_dual = 0, exp_ret = 0, d0, tnum = 0;
   int cycles = 0;

   ddc_dispatch_top ddc_dispatch_top_i (
      .sys_clk_in, .rst_n_in, .fetch_push_in, .fetch_room_out, .slot0_in, .slot1_in,
      .unit_free_in, .disp0_out, .disp1_out, .tag0_out, .tag1_out, .fin_vld_in,
      .fin_tag_in, .fin_exc_in, .ret0_out, .ret1_out, .head_exc_out, .br_vld_in,
      .br_kind_in, .br_link_in, .br_cr_cond_in, .br_taken_in, .cond_false_in,
      .ret_busy_in, .loop_busy_in, .pred_unres_in, .pred_resolve_in, .shadow_release_in,
      .br_ok_out, .br_fold_out, .br_fall_out, .fetch_stall_out, .br_waiting_out,
      .fq_count_out, .int_free_out, .fp_free_out, .shadow_free_out);

   ddc_exec_model ddc_exec_model_i (
      .clk_in(sys_clk_in), .rst_n_in(rst_n_in), .d0_in(disp0_out), .d1_in(disp1_out),
      .t0_in(tag0_out), .t1_in(tag1_out), .hold_in(hold), .rev_in(rev), .exc_in(exc),
      .fin_vld_out(fin_vld_in), .fin_tag_out(fin_tag_in), .fin_exc_out(fin_exc_in));

   always #5 sys_clk_in = ~sys_clk_in;
   // random stalls of the units on top of any forced hold
   always @(posedge sys_clk_in) hold <= hf | ($urandom_range(0, 3) == 0);

   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] obs(input logic [3:0] s);
      case (s)
         4'h0: return {6'h0, disp1_out, disp0_out};
         4'h1: return {4'h0, int_free_out};
         4'h2: return {4'h0, fp_free_out};
         4'h3: return {4'h0, fq_count_out};
         4'h4: return {5'h0, fetch_room_out};
         4'h5: return {4'h0, shadow_free_out};
         4'h6: return {4'h0, br_ok_out, br_fold_out, br_fall_out, fetch_stall_out};
         4'h7: return {6'h0, br_ok_out, fetch_stall_out};
         4'h9: return {7'h0, br_waiting_out};
         default: return {7'h0, head_exc_out};
      endcase
   endfunction

   // outputs settle by the falling edge; every pending note is judged there
   always @(negedge sys_clk_in) begin
      n_ret += int'(ret0_out) + int'(ret1_out);
      n_dual += int'(ret1_out);
      while (q.size() > 0) begin
         ddc_note_s n;
         n = q.pop_front();
         check(obs(n.s), n.e);
      end
   end

   function automatic ddc_instr_s mk(input ddc_unit_e u, input logic [6:0] f);
      return '{1'b1, u, f[6], f[5], f[4], 1'($urandom_range(0, 1)), f[2], f[1], f[0]};
   endfunction

   task automatic cyc(input int n = 1);
      repeat (n) @(posedge sys_clk_in);
   endtask

   task automatic note(input logic [3:0] s, input logic [7:0] e);
      q.push_back({s, e});
   endtask

   task automatic tdone();
      tnum++;
      $display("test %0d done", tnum);
   endtask

   task automatic wait_ret();
      for (int i = 0; i < 60 && n_ret < exp_ret; i++) cyc();
      check(8'(n_ret), 8'(exp_ret));
   endtask

   // load the fetch queue, then offer both bottom entries for one cycle
   task automatic issue(input ddc_instr_s a, input ddc_instr_s b, input logic [1:0] ed);
      fetch_push_in <= b.vld ? 2'h2 : 2'h1;
      cyc();
      fetch_push_in <= 2'h0;
      slot0_in <= a;
      slot1_in <= b;
      note(4'h0, {6'h0, ed});
      cyc();
   endtask

   task automatic drain(input ddc_instr_s a);
      slot0_in <= a;
      slot1_in <= none;
      for (int i = 0; i < 40; i++) begin
         @(negedge sys_clk_in);
         if (fq_count_out === 4'h0 || i == 39) break;
         cyc();
      end
      check({4'h0, fq_count_out}, 8'h00);
      cyc();
   endtask

   task automatic br(input ddc_br_e k, input logic [6:0] f, input logic [3:0] s,
                     input logic [3:0] e);
      br_vld_in <= 1'b1;
      br_kind_in <= k;
      {br_link_in, br_cr_cond_in, br_taken_in, cond_false_in, ret_busy_in, loop_busy_in,
       pred_unres_in} <= f;
      note(s, {4'h0, e});
      cyc();
   endtask

   initial begin
      void'($urandom(32'h8e81));
      i_int = mk(UNIT_INT, 7'h24);
      i_nod = mk(UNIT_INT, 7'h04);
      i_ldu = mk(UNIT_LSU, 7'h64);
      i_ld  = mk(UNIT_LSU, 7'h24);
      i_fpd = mk(UNIT_FPU, 7'h10);
      i_cs  = mk(UNIT_SYS, 7'h02);
      none  = '0;
      {rst_n_in, pred_unres_in, pred_resolve_in, shadow_release_in, br_vld_in, br_link_in,
       br_cr_cond_in, br_taken_in, cond_false_in, ret_busy_in, loop_busy_in, hf, rev,
       exc} = '0;
      fetch_push_in = 2'h0;
      unit_free_in = 4'hf;
      br_kind_in = BR_REL_UNCOND;
      slot0_in = none;
      slot1_in = none;
      cyc(3);
      rst_n_in <= 1'b1;
      slot0_in <= i_int;
      cyc();
      note(4'h1, 8'h06);
      note(4'h2, 8'h06);
      note(4'h5, 8'h01);
      note(4'h4, 8'h02);
      note(4'h0, 8'h00);
      cyc();
      tdone();
      rev <= 1'b1;
      d0 = n_dual;
      issue(i_int, i_ldu, 2'h3);
      note(4'h1, 8'h03);
      exp_ret += 2;
      wait_ret();
      check(8'(n_dual - d0), 8'h00);
      issue(i_int, i_ld, 2'h3);
      exp_ret += 2;
      wait_ret();
      check(8'(n_dual - d0), 8'h01);
      issue(i_int, i_fpd, 2'h3);
      exp_ret += 2;
      wait_ret();
      check(8'(n_dual - d0), 8'h01);
      rev <= 1'b0;
      tdone();
      issue(i_cs, i_int, 2'h1);
      slot0_in <= i_int;
      slot1_in <= none;
      cyc();
      note(4'h0, 8'h00);
      drain(i_int);
      exp_ret += 1;
      check(8'(n_ret), 8'(exp_ret));
      exp_ret += 1;
      issue(i_int, i_int, 2'h1);
      drain(i_int);
      unit_free_in <= 4'he;
      issue(i_int, none, 2'h0);
      unit_free_in <= 4'hf;
      drain(i_int);
      exp_ret += 3;
      wait_ret();
      tdone();
      hf <= 1'b1;
      repeat (3) issue(i_ldu, none, 2'h1);
      note(4'h1, 8'h00);
      issue(i_int, none, 2'h0);
      hf <= 1'b0;
      drain(i_int);
      exp_ret += 4;
      wait_ret();
      tdone();
      hf <= 1'b1;
      repeat (6) issue(i_fpd, none, 2'h1);
      note(4'h2, 8'h00);
      issue(i_nod, none, 2'h0);
      fetch_push_in <= 2'h2;
      cyc(2);
      fetch_push_in <= 2'h1;
      cyc();
      fetch_push_in <= 2'h0;
      note(4'h4, 8'h00);
      hf <= 1'b0;
      drain(i_nod);
      exp_ret += 12;
      wait_ret();
      note(4'h2, 8'h06);
      tdone();
      br(BR_REL_UNCOND, 7'h10, 4'h6, 4'hc);
      br(BR_REL_COND, 7'h00, 4'h6, 4'ha);
      br(BR_REL_COND, 7'h30, 4'h6, 4'hc);
      br(BR_TO_RET, 7'h04, 4'h7, 4'h1);
      br(BR_TO_RET, 7'h00, 4'h7, 4'h2);
      br(BR_TO_LOOP, 7'h02, 4'h7, 4'h1);
      br(BR_LOOP_DEC_COND, 7'h02, 4'h7, 4'h1);
      br(BR_LOOP_DEC_COND, 7'h0a, 4'h7, 4'h2);
      br(BR_REL_COND, 7'h21, 4'h7, 4'h1);
      br(BR_REL_UNCOND, 7'h50, 4'h7, 4'h2);
      br(BR_REL_UNCOND, 7'h50, 4'h7, 4'h1);
      note(4'h5, 8'h00);
      note(4'h9, 8'h01);
      br_vld_in <= 1'b0;
      shadow_release_in <= 1'b1;
      cyc();
      shadow_release_in <= 1'b0;
      note(4'h5, 8'h01);
      tdone();
      pred_unres_in <= 1'b1;
      issue(i_int, none, 2'h1);
      pred_unres_in <= 1'b0;
      cyc(8);
      check(8'(n_ret), 8'(exp_ret));
      pred_resolve_in <= 1'b1;
      cyc();
      pred_resolve_in <= 1'b0;
      exp_ret += 1;
      wait_ret();
      check(8'(n_ret), 8'(exp_ret));
      exc <= 1'b1;
      issue(i_int, none, 2'h1);
      cyc(8);
      note(4'h8, 8'h01);
      check(8'(n_ret), 8'(exp_ret));
      tdone();
      @(negedge sys_clk_in);
      #1;
      end_sim();
   end
endmodule

// ==== testbench/ddc_exec_model.sv ====
// far-side model: execution units that finish dispatched entries
`timescale 1ns/1ps
module ddc_exec_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       d0_in,
   input  wire logic       d1_in,
   input  wire logic [2:0] t0_in,
   input  wire logic [2:0] t1_in,
   input  wire logic       hold_in,
   input  wire logic       rev_in,
   input  wire logic       exc_in,
   output logic            fin_vld_out,
   output logic [2:0]      fin_tag_out,
   output logic            fin_exc_out
);
   logic [2:0] pend[$];
   // idle tag toggles so a stale tag never looks like a real finish
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pend.delete();
         fin_vld_out <= 1'b0;
         fin_tag_out <= 3'h0;
         fin_exc_out <= 1'b0;
      end else begin
         // units may finish out of order, so the youngest can go first
         fin_vld_out <= !hold_in && pend.size() > 0;
         if (!hold_in && pend.size() > 0) begin
            fin_tag_out <= rev_in ? pend.pop_back() : pend.pop_front();
            fin_exc_out <= exc_in;
         end else begin
            fin_tag_out <= ~fin_tag_out;
         end
         if (d0_in) pend.push_back(t0_in);
         if (d1_in) pend.push_back(t1_in);
      end
   end
endmodule
